// ==== pom_top.sv ====
// Purpose: output source multiplexer and driver enable for pin four
// Assumes: status inputs arrive from other domains or pins
// Notes:   a status change reaches the pin three edges later
// Functional notes
// - bits 4:2 pick rx port 0-3, device status 100, tx port 110
// - rx source, select 000-011 drives that port's remote pin 0-3
// - rx source, select 100 lock, 101 pass, 110 frame, 111 line valid
// - device source, 000 local value, 001 OR of enabled rx locks
// - device source, 011 AND of enabled rx pass indications
// - device source, 010 AND of enabled rx lock indications
// - device source, 100 frame sync pulse, 101-111 reserved
// - tx source, 000 AND and 001 OR of selected rx pass status
// - tx source, 010 frame, 011 line, 100 synced, 101 tx interrupt
// - bit 1 holds local value, driven when selected
// - driver enabled only when bit 0 is one
`timescale 1ns/1ps
`default_nettype none
`include "pom_defs.svh"
module pom_top (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output var  logic [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // status sources
  input  wire pom_pkg::pom_rx_t rx_stat_i [4],
  input  wire pom_pkg::pom_tx_t tx_stat_i,
  input  wire logic            frame_sync_pulse_i,
  // pin
  output var  logic            general_pin_four_o,
  output var  logic            general_pin_four_oe_o
);

  // reset release through two flops
  logic rst_s1_r;
  logic rst_b_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_b_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r  <= rst_s1_r;
    end
  end

  // bring every status input into the clock domain
  logic [31:0] rx_raw;
  logic [31:0] rx_syn;
  logic [5:0]  tx_syn;
  logic        fs_syn;
  pom_pkg::pom_rx_t rx_s [4];
  pom_pkg::pom_tx_t tx_s;
  assign rx_raw = {rx_stat_i[3], rx_stat_i[2], rx_stat_i[1], rx_stat_i[0]};
  pom_sync #(.W(39)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_r),
    .d_i     ({rx_raw, tx_stat_i, frame_sync_pulse_i}),
    .q_o     ({rx_syn, tx_syn, fs_syn})
  );
  assign rx_s[0] = rx_syn[7:0];
  assign rx_s[1] = rx_syn[15:8];
  assign rx_s[2] = rx_syn[23:16];
  assign rx_s[3] = rx_syn[31:24];
  assign tx_s    = tx_syn;

  // bus front end
  logic wr_ctl;
  logic wr_ena;
  logic hit;
  pom_apb u_apb (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_r),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pstrb    (pstrb),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_ctl_o (wr_ctl),
    .wr_ena_o (wr_ena),
    .hit_o    (hit)
  );

  // register state
  pom_pkg::pom_ctl_t ctl_r;
  pom_pkg::pom_ctl_t ctl_nxt;
  logic [3:0]        rx_en_r;
  logic [3:0]        rx_en_nxt;
  logic [31:0]       prdata_nxt;
  logic              pin_nxt;
  logic              oe_nxt;
  logic              mux_out;

  // per-port enables for device-wide lock and pass combining
  always_comb begin
    ctl_nxt   = ctl_r;
    rx_en_nxt = rx_en_r;
    if (wr_ctl) begin
      ctl_nxt = pom_pkg::pom_ctl_t'(pwdata[7:0]);
    end
    if (wr_ena) begin
      rx_en_nxt = pwdata[3:0];
    end
  end

  // read mux; status word shows the live pin level and enable
  always_comb begin
    prdata_nxt = prdata;
    if (psel && !penable && !pwrite) begin
      // unmapped reads return zero, never a stale word
      prdata_nxt = 32'h0000_0000;
      if (hit) begin
        case (paddr)
          `POM_CTL_OFFSET:    prdata_nxt = {24'h00_0000, ctl_r};
          `POM_STATUS_OFFSET: prdata_nxt = {30'h0000_0000,
                                            general_pin_four_oe_o,
                                            general_pin_four_o};
          `POM_ENABLE_OFFSET: prdata_nxt = {28'h000_0000, rx_en_r};
          default:            prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // and over the enabled ports; an empty set counts as all true
  function automatic logic and_enabled(input logic [3:0] v,
                                       input logic [3:0] en);
    and_enabled = &(v | ~en);
  endfunction : and_enabled

  // combines over enabled ports; empty set gives and=1, or=0
  logic [3:0] lock_v;
  logic [3:0] pass_v;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lock_v[i] = rx_s[i].lock;
      pass_v[i] = rx_s[i].pass;
    end
  end

  // source and select decode
  always_comb begin
    mux_out = 1'b0;
    case (ctl_r.output_source_select)
      pom_pkg::POM_SRC_RX0, pom_pkg::POM_SRC_RX1,
      pom_pkg::POM_SRC_RX2, pom_pkg::POM_SRC_RX3: begin
        if (!ctl_r.output_signal_select[2]) begin
          mux_out = rx_s[ctl_r.output_source_select[1:0]]
                      .remote_pin[ctl_r.output_signal_select[1:0]];
        end else begin
          case (ctl_r.output_signal_select[1:0])
            2'h0:    mux_out = rx_s[ctl_r.output_source_select[1:0]].lock;
            2'h1:    mux_out = rx_s[ctl_r.output_source_select[1:0]].pass;
            2'h2:    mux_out =
                       rx_s[ctl_r.output_source_select[1:0]].frame_valid;
            default: mux_out =
                       rx_s[ctl_r.output_source_select[1:0]].line_valid;
          endcase
        end
      end
      pom_pkg::POM_SRC_DEV: begin
        case (ctl_r.output_signal_select)
          3'h0:    mux_out = ctl_r.local_output_value;
          3'h1:    mux_out = |(lock_v & rx_en_r);
          3'h2:    mux_out = and_enabled(lock_v, rx_en_r);
          3'h3:    mux_out = and_enabled(pass_v, rx_en_r);
          3'h4:    mux_out = fs_syn;
          default: mux_out = 1'b0;
        endcase
      end
      pom_pkg::POM_SRC_TX0: begin
        case (ctl_r.output_signal_select)
          3'h0:    mux_out = tx_s.pass_and;
          3'h1:    mux_out = tx_s.pass_or;
          3'h2:    mux_out = tx_s.frame_active;
          3'h3:    mux_out = tx_s.line_active;
          3'h4:    mux_out = tx_s.synced;
          3'h5:    mux_out = tx_s.tx_irq;
          default: mux_out = 1'b0;
        endcase
      end
      default: mux_out = 1'b0;
    endcase
  end

  // pin level and driver enable, registered for clean outputs
  always_comb begin
    pin_nxt = mux_out;
    oe_nxt  = ctl_r.output_driver_enable;
  end

  // registers; reset gives disabled pin, rx port 0 pin 0
  always_ff @(posedge clk_i or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ctl_r                 <= pom_pkg::pom_ctl_t'(`POM_CTL_RESET);
      rx_en_r               <= `POM_ENABLE_RESET;
      prdata                <= 32'h0000_0000;
      general_pin_four_o    <= 1'b0;
      general_pin_four_oe_o <= 1'b0;
    end else begin
      ctl_r                 <= ctl_nxt;
      rx_en_r               <= rx_en_nxt;
      prdata                <= prdata_nxt;
      general_pin_four_o    <= pin_nxt;
      general_pin_four_oe_o <= oe_nxt;
    end
  end

endmodule : pom_top
`default_nettype wire

// ==== pom_defs.svh ====
// Purpose: offsets, field positions and reset values of the pin mux block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef POM_DEFS_SVH
`define POM_DEFS_SVH

`define POM_CTL_OFFSET    12'h014
`define POM_STATUS_OFFSET 12'h018
`define POM_ENABLE_OFFSET 12'h01C
`define POM_CTL_RESET     8'h00
`define POM_ENABLE_RESET  4'h0
`define POM_SEL_MSB       7
`define POM_SEL_LSB       5
`define POM_SRC_MSB       4
`define POM_SRC_LSB       2
`define POM_VAL_BIT       1
`define POM_EN_BIT        0

`endif

// ==== pom_pkg.sv ====
// Purpose: types of the pin output source mux
// Assumes: four receive ports, one transmit port
// Notes:   constants live in pom_defs.svh
package pom_pkg;

  // output source field codes
  typedef enum logic [2:0] {
    POM_SRC_RX0  = 3'h0,
    POM_SRC_RX1  = 3'h1,
    POM_SRC_RX2  = 3'h2,
    POM_SRC_RX3  = 3'h3,
    POM_SRC_DEV  = 3'h4,
    POM_SRC_RES5 = 3'h5,
    POM_SRC_TX0  = 3'h6,
    POM_SRC_RES7 = 3'h7
  } pom_src_t;

  // control register layout
  typedef struct packed {
    logic [2:0] output_signal_select;
    pom_src_t   output_source_select;
    logic       local_output_value;
    logic       output_driver_enable;
  } pom_ctl_t;

  // per receive port status
  typedef struct packed {
    logic [3:0] remote_pin;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } pom_rx_t;

  // transmit port status
  typedef struct packed {
    logic pass_and;
    logic pass_or;
    logic frame_active;
    logic line_active;
    logic synced;
    logic tx_irq;
  } pom_tx_t;

endpackage : pom_pkg

// ==== pom_sync.sv ====
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: asynchronous sources, levels only
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pom_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // two stages, reset to zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : pom_sync
`default_nettype wire

// ==== pom_apb.sv ====
// Purpose: apb slave front end, zero wait states
// Assumes: master holds request until pready sampled high
// Notes:   unmapped addresses answer pslverr, read as zero
`timescale 1ns/1ps
`default_nettype none
`include "pom_defs.svh"
module pom_apb (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  // register side
  output logic             wr_ctl_o,
  output logic             wr_ena_o,
  output logic             hit_o
);
  logic access;
  logic setup;
  logic pready_nxt;
  logic pslverr_nxt;

  // access phase completes in one cycle
  assign access   = psel & penable;
  assign setup    = psel & ~penable;
  assign hit_o    = (paddr == `POM_CTL_OFFSET) |
                    (paddr == `POM_STATUS_OFFSET) |
                    (paddr == `POM_ENABLE_OFFSET);

  // answer decided at the setup edge, so it comes from a flop and
  // stands through the whole access phase, dropping right after it
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup & ~hit_o;
  end

  // answer registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end
  // only byte lane 0 carries register bits
  assign wr_ctl_o = access & pwrite & pstrb[0] &
                    (paddr == `POM_CTL_OFFSET);
  assign wr_ena_o = access & pwrite & pstrb[0] &
                    (paddr == `POM_ENABLE_OFFSET);
endmodule : pom_apb
`default_nettype wire

// ==== pom_top_sva.sv ====
// Purpose: port checks of the pin output mux
// Assumes: zero-wait apb, pin and enable registered
// Notes:   bound to pom_top below
`timescale 1ns/1ps
`default_nettype none
`include "pom_defs.svh"
module pom_top_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin
  input wire logic        general_pin_four_o,
  input wire logic        general_pin_four_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic       acc;
  logic       wr;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  // access decode; a control write needs lane 0
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0] && paddr == `POM_CTL_OFFSET;
  // shadow of the control byte, for readback
  always_comb ctl_nxt = wr ? pwdata[7:0] : ctl_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ctl_r <= 8'h00;
    else ctl_r <= ctl_nxt;
  end
  a_oe_follow: assert property (wr |-> ##2
    general_pin_four_oe_o == $past(pwdata[0], 2)) else $error("oe wrong");
  a_oe_steady: assert property ($changed(general_pin_four_oe_o) |->
    $past(wr, 2)) else $error("oe moved alone");
  a_local_value: assert property (wr && pwdata[7:2] == 6'h04 |->
    ##2 general_pin_four_o == $past(pwdata[1], 2)) else $error("local");
  a_src_reserved: assert property (wr && pwdata[3:2] == 2'h3 &&
    pwdata[4] |-> ##2 !general_pin_four_o [*2]) else $error("src res");
  a_dev_reserved: assert property (wr && pwdata[4:2] == 3'h4 &&
    pwdata[7:5] > 3'h4 |-> ##2 !general_pin_four_o [*2]) else $error("dev");
  a_tx_reserved: assert property (wr && pwdata[4:2] == 3'h6 &&
    pwdata[7:5] > 3'h5 |-> ##2 !general_pin_four_o [*2]) else $error("tx");
  a_ctl_readback: assert property (acc && !pwrite &&
    paddr == `POM_CTL_OFFSET |-> prdata == {24'h0, ctl_r}) else $error("rb");
  a_err_unmapped: assert property (acc && !(paddr inside {`POM_CTL_OFFSET,
    `POM_STATUS_OFFSET, `POM_ENABLE_OFFSET}) |-> pslverr && pready &&
    (pwrite || prdata == 32'h0)) else $error("unmapped");
endmodule : pom_top_sva
bind pom_top pom_top_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .general_pin_four_o(general_pin_four_o),
  .general_pin_four_oe_o(general_pin_four_oe_o));
`default_nettype wire

// ==== pom_pin_load.sv ====
// Purpose: load on the pin, a weak pull-down
// Assumes: pin driven only while enable is high
// Notes:   a released pin reads low, never the last value
`timescale 1ns/1ps
`default_nettype none
module pom_pin_load (
  // pin
  input  wire logic pin_i,
  input  wire logic oe_i,
  // line seen outside
  output wire logic line_o
);
  assign line_o = oe_i ? pin_i : 1'b0;
endmodule : pom_pin_load
`default_nettype wire

// ==== tb_pin_output_source_mux.sv ====
// Purpose: self-checking bench of the pin output mux
// Assumes: zero-wait apb, status reaches pin in 3 edges
// Notes:   walks all control codes twice, status random
`timescale 1ns/1ps
`default_nettype none
`include "pom_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module tb_pin_output_source_mux;
  logic             clk_i = 0;
  logic             rst_b_i = 0;
  logic             psel = 0;
  logic             penable = 0;
  logic             pwrite = 0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata, q;
  logic [3:0]       pstrb = 4'hF;
  logic [3:0]       en = 4'h0;
  logic             pready, pslverr, err, pin, oe, line;
  logic             fs = 0;
  pom_pkg::pom_rx_t rx [4] = '{default: '0};
  pom_pkg::pom_tx_t tx = '0;
  int               checks = 0;
  int               failures = 0;
  always #12.5 clk_i = ~clk_i;
  pom_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_stat_i(rx), .tx_stat_i(tx), .frame_sync_pulse_i(fs),
    .general_pin_four_o(pin), .general_pin_four_oe_o(oe));
  pom_pin_load u_load (.pin_i(pin), .oe_i(oe), .line_o(line));
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // expected pin level for a control byte
  function automatic logic exp_pin(logic [7:0] c);
    logic [2:0]       s;
    logic [3:0]       lk, ps;
    logic [7:0]       v;
    pom_pkg::pom_rx_t r;
    s = c[7:5];
    for (int i = 0; i < 4; i++) begin
      lk[i] = rx[i].lock;
      ps[i] = rx[i].pass;
    end
    v = {3'h0, fs, &(ps | ~en), &(lk | ~en), |(lk & en), c[1]};
    if (c[4:2] == 3'h4) return v[s];
    if (c[4]) return (c[4:2] == 3'h6 && s < 3'h6) ? tx[3'h5 - s] : 1'b0;
    r = rx[c[3:2]];
    v = {r[0], r[1], r[2], r[3], r.remote_pin};
    return v[s];
  endfunction : exp_pin
  // verdict, reached from the tests or the watchdog
  task automatic conclude;
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // watchdog, about three times the expected run
  initial begin
    #800_000;
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(85));
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge clk_i);
    apb(0, `POM_CTL_OFFSET, 32'h0);
    `CHK(q, 32'h0)
    `CHK({oe, line}, 2'h0)
    apb(0, 12'h020, 32'h0);
    `CHK({err, q}, {1'b1, 32'h0})
    // a write without byte lane 0 must leave the control byte alone
    pstrb <= 4'hE;
    apb(1, `POM_CTL_OFFSET, 32'h0000_00FF);
    pstrb <= 4'hF;
    apb(0, `POM_CTL_OFFSET, 32'h0);
    `CHK({err, q}, {1'b0, 32'h0})
    for (int i = 0; i < 512; i++) begin
      @(posedge clk_i);
      for (int p = 0; p < 4; p++) rx[p] <= 8'($urandom);
      tx <= 6'($urandom);
      fs <= 1'($urandom);
      en = 4'($urandom);
      apb(1, `POM_ENABLE_OFFSET, {28'h0, en});
      apb(1, `POM_CTL_OFFSET, {24'h0, i[7:0]});
      repeat (4) @(posedge clk_i);
      `CHK(pin, exp_pin(i[7:0]))
      `CHK({oe, line}, {i[0], i[0] & exp_pin(i[7:0])})
      apb(0, `POM_CTL_OFFSET, 32'h0);
      `CHK({err, q}, {1'b0, 24'h0, i[7:0]})
      apb(0, `POM_STATUS_OFFSET, 32'h0);
      `CHK(q, {30'h0, i[0], exp_pin(i[7:0])})
      apb(0, `POM_ENABLE_OFFSET, 32'h0);
      `CHK(q, {28'h0, en})
    end
    conclude();
  end
endmodule : tb_pin_output_source_mux
`default_nettype wire
